// >>> rtl/cpg_gain_decode.sv
/*
  cpg_gain_decode: turns a six-bit gain code into a mute flag and a gain
  in whole decibels. Purely combinational; the caller registers it.
*/
`timescale 1ns/1ps
module cpg_gain_decode
  import cpg_pkg::*;
(
  input  wire logic [5:0] code,
  output cpg_gain_t       gain
);

  always_comb begin
    gain.mute = (code == CPG_CODE_MUTE);
    // each code step is one decibel, code 0x2A is 0 dB
    gain.db   = $signed({1'b0, code}) - $signed({1'b0, CPG_CODE_0DB});
    if (gain.mute) begin
      gain.db = 7'sh00;
    end
  end

endmodule : cpg_gain_decode

// >>> rtl/cpg_gain_regs.sv
/*
  cpg_gain_regs: ADC and DAC gain subregisters behind one shared address,
  with the cycling read sequence and pass-through to the other two
  subregisters. Assumes a same-clock register master: one-cycle strobes,
  read data one cycle later, and sidetone/version data from local logic.
*/
`timescale 1ns/1ps
module cpg_gain_regs
  import cpg_pkg::*;
#(
  parameter int ADDR_W = 4
)(
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic [7:0]        side_rd_data,
  input  wire logic [7:0]        ver_rd_data,
  output logic                   side_wr,
  output logic                   ver_wr,
  output logic      [7:0]        other_wdata,
  output logic      [5:0]        adc_gain_code,
  output logic      [5:0]        dac_gain_code,
  output cpg_gain_t              adc_gain,
  output cpg_gain_t              dac_gain
);

  cpg_req_t      req;
  logic          hit;
  logic          wr_gain;
  logic          rd_gain;
  logic [1:0]    wsel;
  logic [5:0]    wcode;

  logic [5:0]    adc_code_r;
  logic [5:0]    adc_code_nxt;
  logic [5:0]    dac_code_r;
  logic [5:0]    dac_code_nxt;

  cpg_rd_state_t rd_st_r;
  cpg_rd_state_t rd_st_nxt;
  logic [7:0]    rdata_r;
  logic [7:0]    rdata_nxt;

  logic          side_wr_r;
  logic          side_wr_nxt;
  logic          ver_wr_r;
  logic          ver_wr_nxt;
  logic [7:0]    other_wdata_r;
  logic [7:0]    other_wdata_nxt;

  cpg_gain_t     adc_dec;
  cpg_gain_t     dac_dec;
  cpg_gain_t     adc_gain_r;
  cpg_gain_t     adc_gain_nxt;
  cpg_gain_t     dac_gain_r;
  cpg_gain_t     dac_gain_nxt;

  // bus request decode
  always_comb begin
    req.wr    = reg_wr;
    req.rd    = reg_rd;
    req.addr  = 4'(reg_addr);
    req.wdata = reg_wdata;
    hit       = (req.addr == CPG_GAIN_ADDR);
    wr_gain   = req.wr && hit;
    rd_gain   = req.rd && hit;
    wsel      = req.wdata[CPG_SEL_MSB:CPG_SEL_LSB];
    wcode     = req.wdata[CPG_CODE_MSB:CPG_CODE_LSB];
  end

  // gain code subregisters
  always_comb begin
    adc_code_nxt = adc_code_r;
    dac_code_nxt = dac_code_r;
    if (wr_gain) begin
      case (wsel)
        CPG_SEL_ADC: begin
          adc_code_nxt = wcode;
        end
        CPG_SEL_DAC: begin
          dac_code_nxt = wcode;
        end
        default: begin
          // other selectors are not ours to store
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      adc_code_r <= CPG_GAIN_RST;
      dac_code_r <= CPG_GAIN_RST;
    end else begin
      adc_code_r <= adc_code_nxt;
      dac_code_r <= dac_code_nxt;
    end
  end

  // pass-through strobes to the sidetone and version subregisters
  always_comb begin
    side_wr_nxt     = wr_gain && (wsel == CPG_SEL_SIDE);
    ver_wr_nxt      = wr_gain && (wsel == CPG_SEL_VER);
    other_wdata_nxt = other_wdata_r;
    if (side_wr_nxt || ver_wr_nxt) begin
      other_wdata_nxt = req.wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      side_wr_r     <= 1'b0;
      ver_wr_r      <= 1'b0;
      other_wdata_r <= CPG_RDATA_RST;
    end else begin
      side_wr_r     <= side_wr_nxt;
      ver_wr_r      <= ver_wr_nxt;
      other_wdata_r <= other_wdata_nxt;
    end
  end

  // read sequence; writes do not restart it, only reset does
  always_comb begin
    rd_st_nxt = rd_st_r;
    rdata_nxt = CPG_RDATA_RST;
    if (rd_gain) begin
      case (rd_st_r)
        RS_ADC: begin
          rdata_nxt = {CPG_SEL_ADC, adc_code_r};
          rd_st_nxt = RS_DAC;
        end
        RS_DAC: begin
          rdata_nxt = {CPG_SEL_DAC, dac_code_r};
          rd_st_nxt = RS_SIDE;
        end
        RS_SIDE: begin
          rdata_nxt = side_rd_data;
          rd_st_nxt = RS_VER;
        end
        RS_VER: begin
          rdata_nxt = ver_rd_data;
          rd_st_nxt = RS_ADC;
        end
        default: begin
          rd_st_nxt = RS_ADC;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_st_r <= RS_ADC;
      rdata_r <= CPG_RDATA_RST;
    end else begin
      rd_st_r <= rd_st_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // code to mute / decibel mapping, registered for the analog controls
  cpg_gain_decode u_adc_dec (
    .code (adc_code_r),
    .gain (adc_dec)
  );

  cpg_gain_decode u_dac_dec (
    .code (dac_code_r),
    .gain (dac_dec)
  );

  always_comb begin
    adc_gain_nxt = adc_dec;
    dac_gain_nxt = dac_dec;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      adc_gain_r <= CPG_GAIN_ST_RST;
      dac_gain_r <= CPG_GAIN_ST_RST;
    end else begin
      adc_gain_r <= adc_gain_nxt;
      dac_gain_r <= dac_gain_nxt;
    end
  end

  assign reg_rdata     = rdata_r;
  assign side_wr       = side_wr_r;
  assign ver_wr        = ver_wr_r;
  assign other_wdata   = other_wdata_r;
  assign adc_gain_code = adc_code_r;
  assign dac_gain_code = dac_code_r;
  assign adc_gain      = adc_gain_r;
  assign dac_gain      = dac_gain_r;

  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_gain_rd;
    reg_rd && (reg_addr == ADDR_W'(CPG_GAIN_ADDR));
  endsequence

  sequence s_adc_wr;
    reg_wr && (reg_addr == ADDR_W'(CPG_GAIN_ADDR))
      && (reg_wdata[7:6] == CPG_SEL_ADC);
  endsequence

  sequence s_dac_wr;
    reg_wr && (reg_addr == ADDR_W'(CPG_GAIN_ADDR))
      && (reg_wdata[7:6] == CPG_SEL_DAC);
  endsequence

  sequence s_other_wr;
    reg_wr && (reg_addr == ADDR_W'(CPG_GAIN_ADDR)) && reg_wdata[7];
  endsequence

  a_adc_write_load: assert property (
    s_adc_wr |=> (adc_gain_code == $past(reg_wdata[5:0]))
  ) else $error("adc code not loaded from selector 00 write");

  a_adc_code_hold: assert property (
    !$stable(adc_gain_code)
      |-> $past(reg_wr && (reg_addr == ADDR_W'(CPG_GAIN_ADDR))
        && (reg_wdata[7:6] == CPG_SEL_ADC))
  ) else $error("adc code changed without an adc write");

  a_read_order: assert property (
    (s_gain_rd and (rd_st_r == RS_ADC)) ##1 s_gain_rd ##1 s_gain_rd
      |=> (reg_rdata == $past(side_rd_data))
        && ($past(reg_rdata) == {CPG_SEL_DAC, $past(dac_gain_code, 2)})
  ) else $error("read sequence out of order");

  a_read_adc_first: assert property (
    (s_gain_rd and ((rd_st_r == RS_ADC) && !reg_wr))
      |=> reg_rdata == {CPG_SEL_ADC, $past(adc_gain_code)}
  ) else $error("first gain read is not the adc value");

  a_read_wrap: assert property (
    (s_gain_rd and (rd_st_r == RS_VER))
      |=> (reg_rdata == $past(ver_rd_data)) && (rd_st_r == RS_ADC)
  ) else $error("fourth read not version or sequence not wrapped");

  a_adc_mute_map: assert property (
    (adc_gain_code == CPG_CODE_MUTE) |=> adc_gain.mute
  ) else $error("all-ones adc code did not mute");

  a_adc_db_map: assert property (
    (adc_gain_code != CPG_CODE_MUTE)
      |=> !adc_gain.mute
        && (adc_gain.db == $signed({1'b0, $past(adc_gain_code)}) - 7'sd42)
  ) else $error("adc code to decibel mapping wrong");

  a_zero_db_code: assert property (
    (dac_gain_code == 6'h2A) |=> (dac_gain.db == 7'sd0) && !dac_gain.mute
  ) else $error("code 101010 is not 0 dB");

  a_dac_write_load: assert property (
    s_dac_wr |=> (dac_gain_code == $past(reg_wdata[5:0]))
      && $stable(adc_gain_code)
  ) else $error("dac code not loaded from selector 01 write");

  a_dac_map: assert property (
    (dac_gain_code == 6'h3E) |=> (dac_gain.db == 7'sd20) && !dac_gain.mute
  ) else $error("dac top code is not 20 dB");

  a_other_wr_pass: assert property (
    s_other_wr |=> $stable(adc_gain_code) && $stable(dac_gain_code)
      && (side_wr || ver_wr) && (other_wdata == $past(reg_wdata))
  ) else $error("selector 10/11 write disturbed gain or was not passed on");

  // hold checks catch a stray load from an unrelated strobe
  a_dac_code_hold: assert property (
    !$stable(dac_gain_code)
      |-> $past(reg_wr && (reg_addr == ADDR_W'(CPG_GAIN_ADDR))
        && (reg_wdata[7:6] == CPG_SEL_DAC))
  ) else $error("dac code changed without a dac write");

  a_dac_mute_map: assert property (
    (dac_gain_code == CPG_CODE_MUTE) |=> dac_gain.mute && (dac_gain.db == 7'sh00)
  ) else $error("all-ones dac code did not mute");

  a_adc_top_code: assert property (
    (adc_gain_code == 6'h3E) |=> (adc_gain.db == 7'sh14) && !adc_gain.mute
  ) else $error("adc top code is not 20 dB");

  a_adc_floor_code: assert property (
    (adc_gain_code == 6'h00) |=> (adc_gain.db == 7'sh56) && !adc_gain.mute
  ) else $error("adc code 000000 is not -42 dB");

  // other reads must not disturb the gain read order
  a_other_rd_quiet: assert property (
    (reg_rd && (reg_addr != ADDR_W'(CPG_GAIN_ADDR)))
      |=> (reg_rdata == CPG_RDATA_RST) && $stable(rd_st_r)
  ) else $error("unmapped read returned data or moved the read order");

endmodule : cpg_gain_regs

// >>> rtl/cpg_pkg.sv
/*
  cpg_pkg: constants and carrier types for the codec gain register bank.
  Assumes a single 20 MHz core clock domain and one shared gain address.
*/
package cpg_pkg;

  localparam int CPG_CLK_HZ = 20_000_000;

  // address of the shared gain location on the register port
  localparam logic [3:0] CPG_GAIN_ADDR = 4'h5;

  // field positions inside the written byte
  localparam int CPG_SEL_MSB  = 7;
  localparam int CPG_SEL_LSB  = 6;
  localparam int CPG_CODE_MSB = 5;
  localparam int CPG_CODE_LSB = 0;

  // selector values in the top two bits
  localparam logic [1:0] CPG_SEL_ADC  = 2'h0;
  localparam logic [1:0] CPG_SEL_DAC  = 2'h1;
  localparam logic [1:0] CPG_SEL_SIDE = 2'h2;
  localparam logic [1:0] CPG_SEL_VER  = 2'h3;

  // gain code values
  localparam logic [5:0] CPG_GAIN_RST  = 6'h2A;
  localparam logic [5:0] CPG_CODE_MUTE = 6'h3F;
  localparam logic [5:0] CPG_CODE_0DB  = 6'h2A;

  localparam logic [7:0] CPG_RDATA_RST = 8'h00;

  typedef enum logic [1:0] {
    RS_ADC,
    RS_DAC,
    RS_SIDE,
    RS_VER
  } cpg_rd_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } cpg_req_t;

  typedef struct packed {
    logic              mute;
    logic signed [6:0] db;
  } cpg_gain_t;

  localparam cpg_gain_t CPG_GAIN_ST_RST = '{mute: 1'b0, db: 7'sh00};

endpackage : cpg_pkg

// >>> testbench/codec_pga_gain_registers_test.sv
/*
  codec_pga_gain_registers_test: random and directed register traffic,
  compared with a behavioural model every cycle. Assumes one 20 MHz clock.
*/
`timescale 1ns/1ps
module codec_pga_gain_registers_test
  import cpg_pkg::*;
;
  logic       core_clk, rstn, reg_wr, reg_rd, side_wr, ver_wr;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, side_rd_data, ver_rd_data, other_wdata;
  logic [5:0] adc_gain_code, dac_gain_code, m_adc, m_dac, p_adc, p_dac;
  logic [7:0] m_rd, m_oth, op;
  logic       m_side, m_ver;
  cpg_gain_t  adc_gain, dac_gain;
  int         ptr, i, miscompares, total_checks;
  int         seed;
  logic [7:0] dir [10] = '{8'h3F, 8'h7F, 8'h3E, 8'h7E, 8'h00, 8'h40, 8'h83,
                           8'hC5, 8'h15, 8'h6A};

  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;

  cpg_host_model host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
                       .reg_wr(reg_wr), .reg_rd(reg_rd));
  cpg_gain_regs dut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .side_rd_data(side_rd_data), .ver_rd_data(ver_rd_data), .side_wr(side_wr),
    .ver_wr(ver_wr), .other_wdata(other_wdata), .adc_gain_code(adc_gain_code),
    .dac_gain_code(dac_gain_code), .adc_gain(adc_gain), .dac_gain(dac_gain));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    if (miscompares == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  // mute reports zero decibels
  function automatic cpg_gain_t dec(input logic [5:0] c);
    dec.mute = (c == CPG_CODE_MUTE);
    dec.db   = dec.mute ? 7'sh00 : 7'(int'(c) - 42);
  endfunction : dec

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ptr = 0;
      m_adc = CPG_GAIN_RST;
      m_dac = CPG_GAIN_RST;
      p_adc = CPG_GAIN_RST;
      p_dac = CPG_GAIN_RST;
      {m_rd, m_oth, m_side, m_ver} = '0;
    end else begin
      p_adc = m_adc;
      p_dac = m_dac;
      {m_rd, m_side, m_ver} = '0;
      if (reg_rd && reg_addr == CPG_GAIN_ADDR) begin
        case (ptr)
          0: m_rd = {CPG_SEL_ADC, m_adc};
          1: m_rd = {CPG_SEL_DAC, m_dac};
          2: m_rd = side_rd_data;
          default: m_rd = ver_rd_data;
        endcase
        ptr = (ptr + 1) % 4;
      end
      if (reg_wr && reg_addr == CPG_GAIN_ADDR) begin
        case (reg_wdata[7:6])
          CPG_SEL_ADC: m_adc = reg_wdata[5:0];
          CPG_SEL_DAC: m_dac = reg_wdata[5:0];
          CPG_SEL_SIDE: m_side = 1'b1;
          default: m_ver = 1'b1;
        endcase
        if (reg_wdata[7]) m_oth = reg_wdata;
      end
      #1;
      check({2'b00, adc_gain_code}, {2'b00, m_adc});
      check({2'b00, dac_gain_code}, {2'b00, m_dac});
      check(reg_rdata, m_rd);
      check({6'h00, side_wr, ver_wr}, {6'h00, m_side, m_ver});
      check(other_wdata, m_oth);
      check(adc_gain, dec(p_adc));
      check(dac_gain, dec(p_dac));
    end
  end

  task automatic do_reset();
    @(negedge core_clk);
    rstn = 1'b0;
    @(negedge core_clk);
    check({2'b00, adc_gain_code}, 8'h2A);
    check({2'b00, dac_gain_code}, 8'h2A);
    rstn = 1'b1;
  endtask : do_reset

  // cuts a hang short
  initial begin
    repeat (100000) @(posedge core_clk);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    {miscompares, total_checks} = '0;
    seed = 32'h32E3359D;
    rstn = 1'b0;
    side_rd_data = 8'h00;
    ver_rd_data = 8'h00;
    repeat (8) @(posedge core_clk);
    do_reset();
    for (i = 0; i < 10; i++) begin
      host.access(1'b1, 1'b0, CPG_GAIN_ADDR, dir[i]);
      repeat (2) host.access(1'b0, 1'b1, CPG_GAIN_ADDR, 8'h00);
    end
    // four reads in a row walk the whole order once
    side_rd_data <= 8'h5C;
    ver_rd_data <= 8'hD3;
    repeat (4) host.access(1'b0, 1'b1, CPG_GAIN_ADDR, 8'h00);
    // random mix; about one in eight lands off the gain address
    for (i = 0; i < 600; i++) begin
      op = 8'($random(seed));
      host.access(op[0], !op[0] && op[1], (op[4:2] == 3'h0) ? 4'($random(seed))
                  : CPG_GAIN_ADDR, 8'($random(seed)));
      side_rd_data <= 8'($random(seed));
      ver_rd_data <= 8'($random(seed));
      if (i == 300) begin
        host.idle();
        do_reset();
      end
    end
    host.idle();
    repeat (3) @(posedge core_clk);
    tally_and_finish();
  end
endmodule : codec_pga_gain_registers_test

// >>> testbench/cpg_host_model.sv
/*
  cpg_host_model: host side of the register port, one request per call.
  Assumes core_clk is free running and that the caller starts after reset.
*/
`timescale 1ns/1ps
module cpg_host_model
  import cpg_pkg::*;
(
  input  wire logic       core_clk,
  output logic      [3:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  initial begin
    reg_addr  = 4'h0;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // selector 00 or 01 in wdata[7:6] steers the byte to a gain code
  task automatic access(input logic w, input logic r, input logic [3:0] a,
                        input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= w;
    reg_rd    <= r;
    reg_addr  <= a;
    reg_wdata <= d;
  endtask : access

  // idle bus shows no stale request: address and data flipped
  task automatic idle();
    access(1'b0, 1'b0, ~reg_addr, ~reg_wdata);
  endtask : idle
endmodule : cpg_host_model
